// file: rtl/gpm_pkg.sv
// constants, field layouts and carrier types for the nine-pin port block
// assumes a 32-bit apb register bus with byte addresses
package gpm_pkg;
  localparam int GPM_NPIN = 9;
  localparam int GPM_DW = 13;
  localparam int GPM_NLED = 4;
  localparam int GPM_NFN = 4;
  localparam int GPM_AW = 8;
  // register byte offsets
  localparam logic [7:0] GPM_OFS_DATA = 8'h00;
  localparam logic [7:0] GPM_OFS_OE = 8'h04;
  localparam logic [7:0] GPM_OFS_WMASK = 8'h08;
  localparam logic [7:0] GPM_OFS_TYPE = 8'h10;
  localparam logic [7:0] GPM_OFS_POL = 8'h14;
  localparam logic [7:0] GPM_OFS_COND = 8'h20;
  localparam logic [7:0] GPM_OFS_MASK = 8'h24;
  localparam logic [7:0] GPM_OFS_PEND = 8'h28;
  localparam logic [7:0] GPM_OFS_DSET = 8'h30;
  localparam logic [7:0] GPM_OFS_OESET = 8'h34;
  localparam logic [7:0] GPM_OFS_DCLR = 8'h38;
  localparam logic [7:0] GPM_OFS_OECLR = 8'h3c;
  localparam logic [7:0] GPM_OFS_FUNC = 8'h50;
  // reset values
  localparam logic [12:0] GPM_RST_DATA = 13'h0000;
  localparam logic [8:0] GPM_RST_9 = 9'h000;
  localparam logic [8:0] GPM_RST_WMASK = 9'h1ff;
  localparam logic [31:0] GPM_RST_FUNC = 32'h0000_0000;
  // function register layout: one byte lane per pin
  localparam int GPM_FN_STRIDE = 8;
  localparam int GPM_FN_SEL_LSB = 0;
  localparam int GPM_FN_PULL_LSB = 3;
  localparam int GPM_FN_SLOW_BIT = 5;
  localparam logic [31:0] GPM_FN_WR_MASK = 32'h3f3f_3f3f;
  // led bits sit above the pin bits of the data field
  localparam int GPM_LED_LSB = 9;

  typedef enum logic [2:0] {
    GPM_FN_GPIO = 3'b000,
    GPM_FN_I2CM = 3'b011,
    GPM_FN_I2CS = 3'b100,
    GPM_FN_UART = 3'b101,
    GPM_FN_ANA = 3'b111
  } gpm_func_t;

  typedef enum logic [1:0] {
    GPM_PULL_NONE = 2'b00,
    GPM_PULL_UP = 2'b01,
    GPM_PULL_DOWN = 2'b10,
    GPM_PULL_KEEP = 2'b11
  } gpm_pull_t;

  // per-pin electrical setting sent to the pad
  typedef struct packed {
    logic pull_up;
    logic pull_down;
    logic keeper;
    logic slow;
    logic analog;
  } gpm_pad_cfg_t;

  // drive offered by an on-chip peripheral to a pin
  typedef struct packed {
    logic out;
    logic oe;
  } gpm_drive_t;
endpackage

// file: rtl/gpm_gpio_top.sv
// nine-pin general purpose port with masked writes, set/clear strobes,
// per-pin interrupt detection and a pin function selector for pins 0..3
// assumes pad inputs already synchronous to pclk and a zero-wait apb master
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

// Operation
// RULE_01: data register reads return the live pin levels, not written values
// RULE_02: data bits 12:9 drive led pins when front end on and leds enabled
// RULE_03: drive-enable bit one makes the pin output, zero makes it input
// RULE_04: data and drive-enable writes change only mask-selected bits; mask resets 0x1ff; led data bits 12:9 are written unmasked
// RULE_05: sense-type bit zero means level detection, one means edge detection
// RULE_06: level conditions follow the pin; edge conditions stay until software clears
// RULE_07: polarity zero means low or falling, one means high or rising
// RULE_08: condition register shows fulfilled conditions; writing one clears latched edge
// RULE_09: interrupt mask bit one enables the pin interrupt, zero blocks it
// RULE_10: pending bits are ORed into the single interrupt output
// RULE_11: writing ones to data-set strobe sets those data bits only
// RULE_12: writing ones to drive-enable set strobe sets those bits only
// RULE_13: writing ones to data-clear strobe clears those data bits only
// RULE_14: writing ones to drive-enable clear strobe clears those bits only
// RULE_15: pins 0..3 have 3-bit function fields at 2:0,10:8,18:16,26:24, reset zero
// RULE_16: function codes route pin: 0 port, 3 i2c master, 4 i2c slave, 5 uart, 7 analog
// RULE_17: pins 0..3 have 2-bit pull fields at 4:3,12:11,20:19,28:27, reset zero
// RULE_18: pull codes: 0 none, 1 weak up, 2 weak down, 3 keeper
// RULE_19: pins 0..3 have slew bits 5,13,21,29; zero fast, one slow
// RULE_20: each pending bit is condition bit ANDed with its mask bit
// RULE_21: set and clear strobes ignore zero bits and read back as zero
module gpm_gpio_top
  import gpm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [GPM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [GPM_NPIN-1:0] pin_in,
  output logic [GPM_NPIN-1:0] pin_out,
  output logic [GPM_NPIN-1:0] pin_oe_n,
  output gpm_pad_cfg_t [GPM_NFN-1:0] pad_cfg,
  input wire logic [GPM_NLED-1:0] led_pin_in,
  output logic [GPM_NLED-1:0] led_out,
  input wire logic analog_front_end_on,
  input wire logic led_enable,
  input wire gpm_drive_t [GPM_NFN-1:0] i2cm_drive,
  input wire gpm_drive_t [GPM_NFN-1:0] i2cs_drive,
  input wire gpm_drive_t [GPM_NFN-1:0] uart_drive,
  output logic [GPM_NFN-1:0] i2cm_in,
  output logic [GPM_NFN-1:0] i2cs_in,
  output logic [GPM_NFN-1:0] uart_in,
  output logic irq
);

  // software state
  logic [GPM_DW-1:0] data_r;
  logic [GPM_NPIN-1:0] oe_r;
  logic [GPM_NPIN-1:0] wmask_r;
  logic [GPM_NPIN-1:0] type_r;
  logic [GPM_NPIN-1:0] pol_r;
  logic [GPM_NPIN-1:0] cond_r;
  logic [GPM_NPIN-1:0] imask_r;
  logic [31:0] func_r;
  logic [GPM_NPIN-1:0] prev_r;

  // bus decode
  logic wr_acc;
  logic rd_setup;
  logic [GPM_NPIN-1:0] pend;
  logic [GPM_NPIN-1:0] level_hit;
  logic [GPM_NPIN-1:0] edge_hit;
  logic [GPM_NPIN-1:0] cond_clr;
  logic [GPM_NPIN-1:0] wm9;
  logic [GPM_DW-1:0] wm13;
  logic [31:0] rd_nxt;
  logic err_nxt;

  // pin output path
  logic [GPM_NPIN-1:0] out_nxt;
  logic [GPM_NPIN-1:0] oe_nxt;
  gpm_pad_cfg_t [GPM_NFN-1:0] cfg_nxt;

  // function field of pin p
  function automatic gpm_func_t fsel(input logic [31:0] f, input int p);
    fsel = gpm_func_t'(f[p*GPM_FN_STRIDE+GPM_FN_SEL_LSB +: 3]);
  endfunction

  // pull field of pin p
  function automatic gpm_pull_t fpull(input logic [31:0] f, input int p);
    fpull = gpm_pull_t'(f[p*GPM_FN_STRIDE+GPM_FN_PULL_LSB +: 2]);
  endfunction

  // address a matches register offset o
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  // full 13-bit data field, masked over the nine pin bits
  assign wm9 = wmask_r;
  assign wm13 = {{(GPM_DW-GPM_NPIN){1'b1}}, wmask_r};

  // data register: masked write and set/clear strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= GPM_RST_DATA;
    end else if (wr_acc) begin
      if (hit(paddr, GPM_OFS_DATA)) begin
        data_r <= (data_r & ~wm13) | (pwdata[GPM_DW-1:0] & wm13); // RULE_04
      end else if (hit(paddr, GPM_OFS_DSET)) begin
        data_r <= data_r | pwdata[GPM_DW-1:0]; // RULE_11
      end else if (hit(paddr, GPM_OFS_DCLR)) begin
        data_r <= data_r & ~pwdata[GPM_DW-1:0]; // RULE_13
      end
    end
  end

  // drive-enable register: masked write and set/clear strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_r <= GPM_RST_9;
    end else if (wr_acc) begin
      if (hit(paddr, GPM_OFS_OE)) begin
        oe_r <= (oe_r & ~wm9) | (pwdata[GPM_NPIN-1:0] & wm9); // RULE_04
      end else if (hit(paddr, GPM_OFS_OESET)) begin
        oe_r <= oe_r | pwdata[GPM_NPIN-1:0]; // RULE_12
      end else if (hit(paddr, GPM_OFS_OECLR)) begin
        oe_r <= oe_r & ~pwdata[GPM_NPIN-1:0]; // RULE_14
      end
    end
  end

  // write mask applied to later data and drive-enable writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wmask_r <= GPM_RST_WMASK; // RULE_04
    end else if (wr_acc && hit(paddr, GPM_OFS_WMASK)) begin
      wmask_r <= pwdata[GPM_NPIN-1:0];
    end
  end

  // sense type per pin: level or edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_r <= GPM_RST_9;
    end else if (wr_acc && hit(paddr, GPM_OFS_TYPE)) begin
      type_r <= pwdata[GPM_NPIN-1:0]; // RULE_05
    end
  end

  // polarity per pin: low/falling or high/rising
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= GPM_RST_9;
    end else if (wr_acc && hit(paddr, GPM_OFS_POL)) begin
      pol_r <= pwdata[GPM_NPIN-1:0]; // RULE_07
    end
  end

  // interrupt enable mask per pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r <= GPM_RST_9;
    end else if (wr_acc && hit(paddr, GPM_OFS_MASK)) begin
      imask_r <= pwdata[GPM_NPIN-1:0]; // RULE_09
    end
  end

  // function, pull and slew fields of pins 0..3; unused bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_r <= GPM_RST_FUNC; // RULE_15 RULE_17
    end else if (wr_acc && hit(paddr, GPM_OFS_FUNC)) begin
      func_r <= pwdata & GPM_FN_WR_MASK; // RULE_15 RULE_17 RULE_19
    end
  end

  // previous pin level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= GPM_RST_9;
    end else begin
      prev_r <= pin_in;
    end
  end

  // condition detection per pin
  assign level_hit = ~(pin_in ^ pol_r); // RULE_07
  assign edge_hit = (pin_in ^ prev_r) & ~(pin_in ^ pol_r); // RULE_07
  assign cond_clr = (wr_acc && hit(paddr, GPM_OFS_COND)) ? pwdata[GPM_NPIN-1:0] : '0;

  // condition status: level follows pin, edge latches; new edge beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_r <= GPM_RST_9;
    end else begin
      cond_r <= (~type_r & level_hit) // RULE_05 RULE_06
              | (type_r & (edge_hit | (cond_r & ~cond_clr))); // RULE_06 RULE_08
    end
  end

  assign pend = cond_r & imask_r; // RULE_09 RULE_20

  // interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |pend; // RULE_10
    end
  end

  // read mux; strobes and unmapped addresses read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    unique case (paddr)
      GPM_OFS_DATA: rd_nxt[GPM_DW-1:0] = {led_pin_in, pin_in}; // RULE_01
      GPM_OFS_OE: rd_nxt[GPM_NPIN-1:0] = oe_r;
      GPM_OFS_WMASK: rd_nxt[GPM_NPIN-1:0] = wmask_r;
      GPM_OFS_TYPE: rd_nxt[GPM_NPIN-1:0] = type_r;
      GPM_OFS_POL: rd_nxt[GPM_NPIN-1:0] = pol_r;
      GPM_OFS_COND: rd_nxt[GPM_NPIN-1:0] = cond_r; // RULE_08
      GPM_OFS_MASK: rd_nxt[GPM_NPIN-1:0] = imask_r;
      GPM_OFS_PEND: rd_nxt[GPM_NPIN-1:0] = pend;
      GPM_OFS_DSET, GPM_OFS_OESET, GPM_OFS_DCLR, GPM_OFS_OECLR: begin
        rd_nxt = 32'h0000_0000; // RULE_21
      end
      GPM_OFS_FUNC: rd_nxt = func_r;
      default: err_nxt = 1'b1;
    endcase
  end

  // apb ready: zero wait states once out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // read data captured in the setup cycle, held until the next setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
    end
  end

  // unmapped offsets answer with an error, reads and writes alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= err_nxt;
    end
  end

  // pin routing: pins 0..3 follow their function, the rest are port pins
  always_comb begin
    out_nxt = data_r[GPM_NPIN-1:0];
    oe_nxt = oe_r; // RULE_03
    cfg_nxt = '0;
    for (int p = 0; p < GPM_NFN; p++) begin
      unique case (fsel(func_r, p))
        GPM_FN_I2CM: begin
          out_nxt[p] = i2cm_drive[p].out; // RULE_16
          oe_nxt[p] = i2cm_drive[p].oe;
        end
        GPM_FN_I2CS: begin
          out_nxt[p] = i2cs_drive[p].out; // RULE_16
          oe_nxt[p] = i2cs_drive[p].oe;
        end
        GPM_FN_UART: begin
          out_nxt[p] = uart_drive[p].out; // RULE_16
          oe_nxt[p] = uart_drive[p].oe;
        end
        GPM_FN_ANA: begin
          oe_nxt[p] = 1'b0; // RULE_16
          cfg_nxt[p].analog = 1'b1;
        end
        default: begin
          out_nxt[p] = data_r[p];
        end
      endcase
      cfg_nxt[p].pull_up = (fpull(func_r, p) == GPM_PULL_UP); // RULE_18
      cfg_nxt[p].pull_down = (fpull(func_r, p) == GPM_PULL_DOWN); // RULE_18
      cfg_nxt[p].keeper = (fpull(func_r, p) == GPM_PULL_KEEP); // RULE_18
      cfg_nxt[p].slow = func_r[p*GPM_FN_STRIDE+GPM_FN_SLOW_BIT]; // RULE_19
    end
  end

  // pad output value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
    end else begin
      pin_out <= out_nxt;
    end
  end

  // pad drive enable, active low; every pin released while in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_n <= '1;
    end else begin
      pin_oe_n <= ~oe_nxt; // RULE_03
    end
  end

  // pad electrical settings for pins 0..3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_cfg <= '0;
    end else begin
      pad_cfg <= cfg_nxt;
    end
  end

  // peripheral inputs see the pin only when the pin is routed to them
  generate
    for (genvar g = 0; g < GPM_NFN; g++) begin : g_route
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          i2cm_in[g] <= 1'b1;
          i2cs_in[g] <= 1'b1;
          uart_in[g] <= 1'b1;
        end else begin
          i2cm_in[g] <= (fsel(func_r, g) == GPM_FN_I2CM) ? pin_in[g] : 1'b1; // RULE_16
          i2cs_in[g] <= (fsel(func_r, g) == GPM_FN_I2CS) ? pin_in[g] : 1'b1; // RULE_16
          uart_in[g] <= (fsel(func_r, g) == GPM_FN_UART) ? pin_in[g] : 1'b1; // RULE_16
        end
      end
    end
  endgenerate

  // led pins carry the top data bits while front end and leds are on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_out <= '0;
    end else if (analog_front_end_on && led_enable) begin
      led_out <= data_r[GPM_DW-1:GPM_LED_LSB]; // RULE_02
    end else begin
      led_out <= '0;
    end
  end

endmodule

// file: verif/gpm_gpio_asserts.sv
// checker for the nine-pin port: strobes, led gate, irq mask, live reads
// bound to gpm_gpio_top, sees its ports only
`timescale 1ns/1ps
module gpm_asserts
  import gpm_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [GPM_AW-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pslverr,
  input logic [GPM_NPIN-1:0] pin_in,
  input logic [GPM_NPIN-1:0] pin_out,
  input logic [GPM_NPIN-1:0] pin_oe_n,
  input logic [GPM_NLED-1:0] led_out,
  input logic analog_front_end_on,
  input logic led_enable,
  input logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  // a write takes effect on the access edge
  assign wr = psel && penable && pwrite;
  // pins 8..4 are always port pins, so strobes show there unhindered
  property strobe_p(ofs, bit oe, bit clr);
    logic [4:0] q, d;
    (wr && paddr == ofs, q = oe ? ~pin_oe_n[8:4] : pin_out[8:4], d = pwdata[8:4])
      |-> ##2 (oe ? ~pin_oe_n[8:4] : pin_out[8:4]) == (clr ? q & ~d : q | d);
  endproperty
  // a data read carries the pin levels seen at the setup edge
  property live_p;
    logic [8:0] v;
    (psel && !penable && !pwrite && paddr == GPM_OFS_DATA, v = pin_in) |=> prdata[8:0] == v;
  endproperty
  chk_data_set: assert property (strobe_p(GPM_OFS_DSET, 0, 0))
    else $error("data set strobe wrong");
  chk_oe_set: assert property (strobe_p(GPM_OFS_OESET, 1, 0))
    else $error("drive set strobe wrong");
  chk_data_clear: assert property (strobe_p(GPM_OFS_DCLR, 0, 1))
    else $error("data clear strobe wrong");
  chk_oe_clear: assert property (strobe_p(GPM_OFS_OECLR, 1, 1))
    else $error("drive clear strobe wrong");
  chk_live_read: assert property (live_p)
    else $error("data read not the pin level");
  chk_mask_blocks: assert property (wr && paddr == GPM_OFS_MASK && pwdata[8:0] == 9'h000
    |-> ##3 !irq)
    else $error("irq with all pins masked");
  chk_led_gate: assert property (!(analog_front_end_on && led_enable) [*2]
    |-> led_out == 4'h0)
    else $error("led driven while gated");
  chk_reset_input: assert property ($rose(presetn) |-> pin_oe_n == 9'h1ff)
    else $error("pin driven after reset");
  cover property ($rose(irq));
  cover property (wr && paddr == GPM_OFS_DCLR);
  cover property (pslverr);
endmodule

bind gpm_gpio_top gpm_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .pin_in, .pin_out, .pin_oe_n, .led_out, .analog_front_end_on,
  .led_enable, .irq);

// file: verif/gpm_pin_model.sv
// board side of the port: nine pin lines and four led lines
// assumes board drivers hold every port line the block leaves undriven
`timescale 1ns/1ps
module gpm_pin_model
  import gpm_pkg::*;
(
  input logic [GPM_NPIN-1:0] pin_out,
  input logic [GPM_NPIN-1:0] pin_oe_n,
  input logic [GPM_NPIN-1:0] ext_lvl,
  input logic [GPM_NLED-1:0] led_out,
  output logic [GPM_NPIN-1:0] pin_in,
  output logic [GPM_NLED-1:0] led_pin_in
);
  // a driven pin shows the block's value, otherwise the board level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
  // led lines read back what the led driver puts out
  assign led_pin_in = led_out;
endmodule

// file: verif/test_gpio_port_irq_pinmux.sv
// self-checking bench for the nine-pin port: apb master and board levels
// assumes the pin model and the bound checker are compiled before it
`timescale 1ns/1ps
module test_gpio_port_irq_pinmux import gpm_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, afe = 0, le = 0;
  logic pready, pslverr, irq, slv, lv;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, fw;
  logic [8:0] pin_in, pin_out, pin_oe_n, ext = '0, m, o, t, p, e0, cnd, eo = '0;
  logic [12:0] ed, edd = '0;
  logic [3:0] led_pin_in, led_out, i2cm_in, i2cs_in, uart_in;
  logic [2:0] f;
  logic [1:0] pl;
  logic [7:0] ofs [11] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h24, 8'h28, 8'h50, 8'h30, 8'h34,
    8'h38, 8'h3c};
  gpm_pad_cfg_t [3:0] pad_cfg;
  gpm_drive_t [3:0] dm = '0, ds = '0, du = '0;
  gpm_drive_t dv;
  int errors = 0, checks = 0, cyc = 0;
  always #10 pclk = ~pclk;
  gpm_gpio_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n, .pad_cfg, .led_pin_in, .led_out,
    .analog_front_end_on(afe), .led_enable(le), .i2cm_drive(dm), .i2cs_drive(ds),
    .uart_drive(du), .i2cm_in, .i2cs_in, .uart_in, .irq);
  gpm_pin_model u_pins (.pin_out, .pin_oe_n, .ext_lvl(ext), .led_out, .pin_in, .led_pin_in);
  // cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // one apb transfer: setup, access held until pready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    bus(0, a, 32'h0);
    chk(rd, x);
  endtask
  // level seen on each pin given drive enable, data and board level
  function automatic logic [8:0] lvl(input logic [8:0] oe, input logic [8:0] d,
    input logic [8:0] e);
    return (oe & d) | (~oe & e);
  endfunction
  function automatic logic [31:0] dexp();
    return {19'h0, afe & le ? edd[12:9] : 4'h0, lvl(eo, edd[8:0], ext)};
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(61));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    foreach (ofs[i]) rchk(ofs[i], ofs[i] == 8'h08 ? 32'h1ff : 32'h0);
    rchk(8'h0c, 32'h0);
    chk({31'h0, slv}, 32'h1);
    $display("test reset done");
    repeat (8) begin
      m = 9'($urandom);
      o = 9'($urandom);
      ed = 13'($urandom);
      ext <= 9'($urandom);
      afe <= 1'($urandom);
      le <= 1'($urandom);
      bus(1, 8'h08, {23'h0, m});
      bus(1, 8'h04, {23'h0, o});
      bus(1, 8'h00, {19'h0, ed});
      eo = (eo & ~m) | (o & m);
      edd = {ed[12:9], (edd[8:0] & ~m) | (ed[8:0] & m)};
      repeat (3) @(posedge pclk);
      rchk(8'h04, {23'h0, eo});
      rchk(8'h00, dexp());
    end
    $display("test masked done");
    bus(1, 8'h08, 32'h1ff);
    for (int k = 0; k < 4; k++) begin
      ed = 13'($urandom);
      bus(1, 8'h30 + 8'(4 * k), {19'h0, ed});
      if (k[0]) eo = k[1] ? eo & ~ed[8:0] : eo | ed[8:0];
      else edd = k[1] ? edd & ~ed : edd | ed;
      repeat (3) @(posedge pclk);
      rchk(8'h04, {23'h0, eo});
      rchk(8'h00, dexp());
    end
    $display("test strobes done");
    bus(1, 8'h04, 32'h0);
    for (int n = 0; n < 6; n++) begin
      t = 9'($urandom);
      p = 9'($urandom);
      m = n == 0 ? 9'h0 : 9'($urandom);
      e0 = 9'($urandom);
      bus(1, 8'h10, {23'h0, t});
      bus(1, 8'h14, {23'h0, p});
      bus(1, 8'h24, {23'h0, m});
      ext <= e0;
      repeat (3) @(posedge pclk);
      bus(1, 8'h20, 32'h1ff);
      ext <= 9'($urandom);
      repeat (3) @(posedge pclk);
      cnd = ~(ext ^ p) & (~t | (e0 ^ ext));
      rchk(8'h20, {23'h0, cnd});
      rchk(8'h28, {23'h0, cnd & m});
      chk({31'h0, irq}, {31'h0, |(cnd & m)});
      bus(1, 8'h20, 32'h1ff);
      repeat (2) @(posedge pclk);
      rchk(8'h20, {23'h0, cnd & ~t});
    end
    $display("test interrupts done");
    repeat (6) begin
      fw = $urandom;
      ext <= 9'($urandom);
      dm <= 8'($urandom);
      ds <= 8'($urandom);
      du <= 8'($urandom);
      bus(1, 8'h50, fw);
      repeat (3) @(posedge pclk);
      rchk(8'h50, fw & 32'h3f3f3f3f);
      for (int i = 0; i < 4; i++) begin
        f = fw[8*i +: 3];
        pl = fw[8*i+3 +: 2];
        // drive the pad should carry: routed peripheral, else port data with drive off
        dv = f == 3 ? dm[i] : f == 4 ? ds[i] : f == 5 ? du[i] : {edd[i], 1'b0};
        lv = dv.oe ? dv.out : ext[i];
        chk(32'(pad_cfg[i]), 32'({pl == 1, pl == 2, pl == 3, fw[8*i+5], f == 7}));
        chk(32'({pin_out[i], ~pin_oe_n[i]}), 32'(dv));
        chk(32'({i2cm_in[i], i2cs_in[i], uart_in[i]}),
          32'({f != 3 | lv, f != 4 | lv, f != 5 | lv}));
      end
    end
    $display("test functions done");
    finish_test();
  end
endmodule
